// [core/eeac_pkg.sv]
package eeac_pkg;
  localparam int EEAC_ADDR_W = 6;
  localparam int EEAC_DEPTH = 64;
  localparam logic [5:0] EEAC_OFS_CONTROL = 6'h1C;
  localparam logic [5:0] EEAC_OFS_DATA = 6'h1D;
  localparam logic [5:0] EEAC_OFS_ADDRESS = 6'h1E;
  localparam int EEAC_BIT_READ = 0;
  localparam int EEAC_BIT_WRITE = 1;
  localparam int EEAC_BIT_ARM = 2;
  localparam int EEAC_BIT_RIE = 3;
  localparam logic [7:0] EEAC_DATA_RESET = 8'h00;
  localparam logic [3:0] EEAC_CTRL_RESET = 4'h0;
  localparam int EEAC_ARM_CYCLES = 4;
  localparam int EEAC_STALL_CYCLES = 2;
  localparam int EEAC_CLK_HZ = 20000000;
  localparam int EEAC_WRITE_US = 4000;
  localparam longint EEAC_WRITE_CYCLES_L = (longint'(EEAC_WRITE_US) * EEAC_CLK_HZ) / 1000000;
  localparam int EEAC_WRITE_CYCLES = int'(EEAC_WRITE_CYCLES_L);
  typedef enum logic [1:0] {
    EEAC_IDLE = 2'b00,
    EEAC_WRITING = 2'b01
  } eeac_wstate_e;
endpackage : eeac_pkg

// [core/eeac_cell_array.sv]
`timescale 1ns/1ps
`default_nettype none
module eeac_cell_array #(
  parameter int DEPTH = 64,
  parameter int AW = 6
) (
  input wire logic mclk,
  input wire logic wr_en,
  input wire logic [AW-1:0] addr,
  input wire logic [7:0] wr_data,
  output logic [7:0] rd_data
);
  logic [7:0] cells [DEPTH];

  initial begin
    if (DEPTH != (1 << AW)) $error("depth must match address width");
  end

  always_ff @(posedge mclk) begin
    if (wr_en) begin
      cells[addr] <= wr_data;
    end
  end

  assign rd_data = cells[addr];
endmodule : eeac_cell_array
`default_nettype wire

// [core/eeac_access.sv]
`timescale 1ns/1ps
`default_nettype none
module eeac_access #(
  parameter int WRITE_CYCLES = eeac_pkg::EEAC_WRITE_CYCLES
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [5:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  input wire logic global_int_en,
  output logic [7:0] io_rdata,
  output logic cpu_stall,
  output logic ready_irq
);
  import eeac_pkg::*;

  initial begin
    if (WRITE_CYCLES < 1) $error("write time must be at least one cycle");
  end

  logic [EEAC_ADDR_W-1:0] cell_address_reg;
  logic [7:0] cell_data_reg;
  logic ready_int_enable;
  logic master_write_arm;
  logic write_strobe_busy;
  logic read_strobe;
  logic [2:0] arm_cnt_reg;
  logic [1:0] stall_cnt_reg;
  logic [31:0] wtime_reg;
  eeac_wstate_e wstate_reg;
  logic [7:0] cell_rd;
  logic wr_ctrl, wr_data, wr_addr;
  logic start_write, start_read, abort_write, cell_we;

  assign wr_ctrl = io_wr && io_addr == EEAC_OFS_CONTROL;
  assign wr_data = io_wr && io_addr == EEAC_OFS_DATA;
  assign wr_addr = io_wr && io_addr == EEAC_OFS_ADDRESS;
  assign start_write = wr_ctrl && io_wdata[EEAC_BIT_WRITE] && master_write_arm
    && !write_strobe_busy;
  assign start_read = wr_ctrl && io_wdata[EEAC_BIT_READ] && !write_strobe_busy;
  assign abort_write = write_strobe_busy && (wr_data || wr_addr);
  assign cell_we = start_write;

  eeac_cell_array #(
    .DEPTH(EEAC_DEPTH),
    .AW(EEAC_ADDR_W)
  ) u_cells (
    .mclk(mclk),
    .wr_en(cell_we),
    .addr(cell_address_reg),
    .wr_data(cell_data_reg),
    .rd_data(cell_rd)
  );

  // no reset: contents survive reset
  always_ff @(posedge mclk) begin
    if (wr_addr) begin
      cell_address_reg <= io_wdata[EEAC_ADDR_W-1:0];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cell_data_reg <= EEAC_DATA_RESET;
    end else if (read_strobe) begin
      cell_data_reg <= cell_rd;
    end else if (wr_data) begin
      cell_data_reg <= io_wdata;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ready_int_enable <= EEAC_CTRL_RESET[EEAC_BIT_RIE];
    end else if (wr_ctrl) begin
      ready_int_enable <= io_wdata[EEAC_BIT_RIE];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      master_write_arm <= EEAC_CTRL_RESET[EEAC_BIT_ARM];
      arm_cnt_reg <= 3'h0;
    end else if (wr_ctrl && io_wdata[EEAC_BIT_ARM]) begin
      master_write_arm <= 1'b1;
      arm_cnt_reg <= 3'(EEAC_ARM_CYCLES - 1);
    end else if (master_write_arm) begin
      if (arm_cnt_reg == 3'h0) begin
        master_write_arm <= 1'b0;
      end else begin
        arm_cnt_reg <= arm_cnt_reg - 3'h1;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      read_strobe <= EEAC_CTRL_RESET[EEAC_BIT_READ];
    end else begin
      read_strobe <= start_read;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wstate_reg <= EEAC_IDLE;
      write_strobe_busy <= EEAC_CTRL_RESET[EEAC_BIT_WRITE];
      wtime_reg <= 32'h0;
    end else begin
      case (wstate_reg)
        EEAC_IDLE: begin
          if (start_write) begin
            wstate_reg <= EEAC_WRITING;
            write_strobe_busy <= 1'b1;
            wtime_reg <= 32'(WRITE_CYCLES - 1);
          end
        end
        EEAC_WRITING: begin
          if (abort_write || wtime_reg == 32'h0) begin
            wstate_reg <= EEAC_IDLE;
            write_strobe_busy <= 1'b0;
          end else begin
            wtime_reg <= wtime_reg - 32'h1;
          end
        end
        default: begin
          wstate_reg <= EEAC_IDLE;
          write_strobe_busy <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      stall_cnt_reg <= 2'h0;
      cpu_stall <= 1'b0;
    end else if (start_write || start_read) begin
      stall_cnt_reg <= 2'(EEAC_STALL_CYCLES - 1);
      cpu_stall <= 1'b1;
    end else if (stall_cnt_reg != 2'h0) begin
      stall_cnt_reg <= stall_cnt_reg - 2'h1;
    end else begin
      cpu_stall <= 1'b0;
    end
  end

  // level request, dropped early when a write starts or enable clears
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ready_irq <= 1'b0;
    end else begin
      ready_irq <= ready_int_enable && global_int_en && !write_strobe_busy
        && !start_write && !(wr_ctrl && !io_wdata[EEAC_BIT_RIE]);
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      io_rdata <= 8'h00;
    end else if (io_rd) begin
      case (io_addr)
        EEAC_OFS_CONTROL: io_rdata <= {4'h0, ready_int_enable, master_write_arm,
          write_strobe_busy, read_strobe};
        EEAC_OFS_DATA: io_rdata <= cell_data_reg;
        EEAC_OFS_ADDRESS: io_rdata <= {2'h0, cell_address_reg};
        default: io_rdata <= 8'h00;
      endcase
    end
  end

  // busy length, read only by the write time check
  logic [31:0] busy_len_reg;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      busy_len_reg <= 32'h0;
    end else if (!write_strobe_busy) begin
      busy_len_reg <= 32'h0;
    end else begin
      busy_len_reg <= busy_len_reg + 32'h1;
    end
  end

  chk_arm_timeout: assert property (@(posedge mclk) disable iff (!rst_n)
    (wr_ctrl && io_wdata[EEAC_BIT_ARM]) ##1 (!wr_ctrl)[*4] |=> !master_write_arm)
    else $error("arm bit did not time out");

  chk_arm_holds: assert property (@(posedge mclk) disable iff (!rst_n)
    (wr_ctrl && io_wdata[EEAC_BIT_ARM]) |=> master_write_arm[*4])
    else $error("arm bit dropped early");

  chk_write_gated: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(write_strobe_busy) |-> $past(master_write_arm))
    else $error("write started without arm");

  chk_unarmed_ignored: assert property (@(posedge mclk) disable iff (!rst_n)
    (wr_ctrl && io_wdata[EEAC_BIT_WRITE] && !master_write_arm && !write_strobe_busy)
    |=> !write_strobe_busy)
    else $error("write started by unarmed strobe");

  chk_stall_two: assert property (@(posedge mclk) disable iff (!rst_n)
    (start_read || start_write) |=> cpu_stall[*2])
    else $error("stall shorter than two cycles");

  chk_stall_end: assert property (@(posedge mclk) disable iff (!rst_n)
    (start_read || start_write) ##1 (!(start_read || start_write))[*2] |=> !cpu_stall)
    else $error("stall longer than two cycles");

  chk_stall_refused: assert property (@(posedge mclk) disable iff (!rst_n)
    (wr_ctrl && !start_write && !start_read && !cpu_stall) |=> !cpu_stall)
    else $error("stall without accepted strobe");

  chk_read_start: assert property (@(posedge mclk) disable iff (!rst_n)
    start_read |=> read_strobe)
    else $error("read strobe not raised");

  chk_read_clear: assert property (@(posedge mclk) disable iff (!rst_n)
    read_strobe |=> !read_strobe)
    else $error("read strobe not cleared");

  chk_read_data: assert property (@(posedge mclk) disable iff (!rst_n)
    read_strobe |=> cell_data_reg == $past(cell_rd))
    else $error("read data not loaded");

  chk_read_gated: assert property (@(posedge mclk) disable iff (!rst_n)
    (wr_ctrl && io_wdata[EEAC_BIT_READ] && write_strobe_busy) |=> !read_strobe)
    else $error("read accepted while busy");

  chk_data_write: assert property (@(posedge mclk) disable iff (!rst_n)
    (wr_data && !read_strobe) |=> cell_data_reg == $past(io_wdata))
    else $error("data register write lost");

  chk_data_hold: assert property (@(posedge mclk) disable iff (!rst_n)
    (!wr_data && !read_strobe) |=> $stable(cell_data_reg))
    else $error("data register changed unasked");

  chk_abort_write: assert property (@(posedge mclk) disable iff (!rst_n)
    abort_write |=> !write_strobe_busy)
    else $error("write not aborted");

  chk_busy_start: assert property (@(posedge mclk) disable iff (!rst_n)
    start_write |=> write_strobe_busy)
    else $error("busy flag not set by write");

  chk_busy_time: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(write_strobe_busy) |-> write_strobe_busy[*2] or ##1 $past(abort_write))
    else $error("busy flag too short");

  chk_busy_len: assert property (@(posedge mclk) disable iff (!rst_n)
    $fell(write_strobe_busy)
    |-> busy_len_reg == 32'(WRITE_CYCLES) || $past(abort_write))
    else $error("busy time differs from write time");

  chk_irq_level: assert property (@(posedge mclk) disable iff (!rst_n)
    ready_irq |-> ready_int_enable && !write_strobe_busy)
    else $error("ready request while busy or disabled");

  chk_irq_gie: assert property (@(posedge mclk) disable iff (!rst_n)
    ready_irq |-> $past(global_int_en))
    else $error("ready request without global enable");

  chk_irq_on: assert property (@(posedge mclk) disable iff (!rst_n)
    (ready_int_enable && global_int_en && !write_strobe_busy && !wr_ctrl) |=> ready_irq)
    else $error("ready request missing");

  chk_rie_write: assert property (@(posedge mclk) disable iff (!rst_n)
    wr_ctrl |=> ready_int_enable == $past(io_wdata[EEAC_BIT_RIE]))
    else $error("ready enable not written");

  chk_irq_drop: assert property (@(posedge mclk) disable iff (!rst_n)
    start_write |=> !ready_irq)
    else $error("ready request kept after write start");

  chk_irq_rie: assert property (@(posedge mclk) disable iff (!rst_n)
    (wr_ctrl && !io_wdata[EEAC_BIT_RIE]) |=> !ready_irq)
    else $error("ready request kept after enable cleared");

  chk_ctrl_upper: assert property (@(posedge mclk) disable iff (!rst_n)
    $past(io_rd && io_addr == EEAC_OFS_CONTROL) |-> io_rdata[7:4] == 4'h0)
    else $error("control upper bits not zero");

  chk_ctrl_busy: assert property (@(posedge mclk) disable iff (!rst_n)
    $past(io_rd && io_addr == EEAC_OFS_CONTROL)
    |-> io_rdata[EEAC_BIT_WRITE] == $past(write_strobe_busy))
    else $error("busy bit not shown in control");

  chk_addr_upper: assert property (@(posedge mclk) disable iff (!rst_n)
    $past(io_rd && io_addr == EEAC_OFS_ADDRESS) |-> io_rdata[7:6] == 2'h0)
    else $error("address upper bits not zero");
endmodule : eeac_access
`default_nettype wire

// [test/eeac_cpu_model.sv]
`timescale 1ns/1ps
`default_nettype none
module eeac_cpu_model (
  input wire logic mclk,
  input wire logic [7:0] io_rdata,
  output logic [5:0] io_addr,
  output logic io_wr,
  output logic io_rd,
  output logic [7:0] io_wdata,
  output logic global_int_en
);
  initial begin
    io_addr = 6'h00;
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_wdata = 8'h00;
    global_int_en = 1'b0;
  end
  // released lines show the inverse of the last value
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge mclk);
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    @(negedge mclk);
    io_wr = 1'b0;
    io_addr = ~a;
    io_wdata = ~d;
  endtask : wr
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(negedge mclk);
    io_addr = a;
    io_rd = 1'b1;
    @(negedge mclk);
    io_rd = 1'b0;
    io_addr = ~a;
    d = io_rdata;
  endtask : rd
  task automatic set_gie(input logic g);
    @(negedge mclk);
    global_int_en = g;
  endtask : set_gie
  // interrupts held off across arm and strobe
  task automatic arm_write(input logic [7:0] c);
    logic g;
    g = global_int_en;
    global_int_en = 1'b0;
    wr(eeac_pkg::EEAC_OFS_CONTROL, c | 8'h04);
    wr(eeac_pkg::EEAC_OFS_CONTROL, c | 8'h06);
    global_int_en = g;
  endtask : arm_write
  task automatic wait_idle(output logic [7:0] d);
    d = 8'h02;
    for (int n = 0; n < 64 && d[1] !== 1'b0; n++) rd(eeac_pkg::EEAC_OFS_CONTROL, d);
  endtask : wait_idle
endmodule : eeac_cpu_model
`default_nettype wire

// [test/eeac_access_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module eeac_access_tb;
  import eeac_pkg::*;
  logic mclk, rst_n, io_wr, io_rd, gie, cpu_stall, ready_irq;
  logic [5:0] io_addr, a;
  logic [7:0] io_wdata, io_rdata, v, d;
  int miscompares, cmp_count, seed;
  always #25 mclk = ~mclk;
  eeac_access #(.WRITE_CYCLES(20)) uut (.mclk(mclk), .rst_n(rst_n), .io_addr(io_addr),
    .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .global_int_en(gie),
    .io_rdata(io_rdata), .cpu_stall(cpu_stall), .ready_irq(ready_irq));
  eeac_cpu_model cpu (.mclk(mclk), .io_rdata(io_rdata), .io_addr(io_addr), .io_wr(io_wr),
    .io_rd(io_rd), .io_wdata(io_wdata), .global_int_en(gie));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  function automatic logic [7:0] ctrl_exp(input logic rie, input logic arm, input logic busy);
    return {4'h0, rie, arm, busy, 1'b0};
  endfunction : ctrl_exp
  task automatic stall_chk();
    for (int i = 0; i < 3; i++) begin
      chk("cpu_stall", {7'h00, i < 2}, {7'h00, cpu_stall});
      @(negedge mclk);
    end
  endtask : stall_chk
  task automatic final_report();
    if (miscompares == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : final_report
  initial begin
    #(50 * 5000);
    miscompares++;
    final_report();
  end
  initial begin
    mclk = 1'b0;
    rst_n = 1'b0;
    seed = 6857;
    miscompares = 0;
    cmp_count = 0;
    repeat (10) @(negedge mclk);
    rst_n = 1'b1;
    cpu.rd(EEAC_OFS_CONTROL, v);
    chk("control", ctrl_exp(1'b0, 1'b0, 1'b0), v);
    cpu.rd(EEAC_OFS_DATA, v);
    chk("data", 8'h00, v);
    cpu.wr(EEAC_OFS_CONTROL, 8'hF2);
    cpu.rd(EEAC_OFS_CONTROL, v);
    chk("unarmed", ctrl_exp(1'b0, 1'b0, 1'b0), v);
    cpu.wr(EEAC_OFS_CONTROL, 8'h04);
    cpu.rd(EEAC_OFS_CONTROL, v);
    chk("arm", ctrl_exp(1'b0, 1'b1, 1'b0), v);
    repeat (3) @(negedge mclk);
    cpu.rd(EEAC_OFS_CONTROL, v);
    chk("arm_timeout", 8'h00, v);
    for (int k = 0; k < 4; k++) begin
      a = 6'($random(seed));
      d = 8'($random(seed));
      if (k == 0) a = 6'h3F;
      if (k == 1) a = 6'h00;
      cpu.set_gie(k[0]);
      cpu.wr(EEAC_OFS_ADDRESS, {2'b00, a});
      cpu.wr(EEAC_OFS_DATA, d);
      cpu.rd(EEAC_OFS_ADDRESS, v);
      chk("address", {2'b00, a}, v);
      cpu.arm_write(8'h08);
      chk("irq_start", 8'h00, {7'h00, ready_irq});
      stall_chk();
      cpu.wait_idle(v);
      chk("busy_done", ctrl_exp(1'b1, 1'b0, 1'b0), v);
      chk("irq_ready", {7'h00, k[0]}, {7'h00, ready_irq});
      cpu.wr(EEAC_OFS_DATA, ~d);
      cpu.wr(EEAC_OFS_CONTROL, 8'h09);
      stall_chk();
      cpu.rd(EEAC_OFS_DATA, v);
      chk("cell", d, v);
    end
    // armed write with interrupts left on: only the start itself drops the request
    cpu.wr(EEAC_OFS_CONTROL, 8'h0C);
    cpu.wr(EEAC_OFS_CONTROL, 8'h0E);
    chk("irq_drop", 8'h00, {7'h00, ready_irq});
    cpu.wait_idle(v);
    chk("irq_back", 8'h01, {7'h00, ready_irq});
    cpu.wr(EEAC_OFS_CONTROL, 8'h00);
    chk("irq_off", 8'h00, {7'h00, ready_irq});
    cpu.arm_write(8'h00);
    cpu.wr(EEAC_OFS_CONTROL, 8'h01);
    chk("read_refused", 8'h00, {7'h00, cpu_stall});
    cpu.wr(EEAC_OFS_DATA, 8'h5A);
    cpu.rd(EEAC_OFS_CONTROL, v);
    chk("abort", ctrl_exp(1'b0, 1'b0, 1'b0), v);
    rst_n = 1'b0;
    repeat (2) @(negedge mclk);
    rst_n = 1'b1;
    cpu.rd(EEAC_OFS_ADDRESS, v);
    chk("addr_kept", {2'b00, a}, v);
    cpu.rd(EEAC_OFS_DATA, v);
    chk("data_reset", 8'h00, v);
    final_report();
  end
endmodule : eeac_access_tb
`default_nettype wire
